// File: interp_coarse_mixer_params.svh
// constants for the coarse-mixing interpolation datapath
// Operation
// - coarse shift happens inside half-band stages
// - offsets only multiples of input rate
// - each mode equals complex carrier multiply
// - half-rate mode: per-channel sign alternation only
// - other modes cross-couple I and Q; MIX_NONE passes them unchanged
// - quarter and three-quarter sequences as listed
// - eighth-rate eight-phase sequence, r is sqrt2/2
// - tuning word is fc/fnco times 2^32
// - bus line rate limits per bus width
// - complex bandwidth twice real bandwidth
// - 8x modes 2,2,1 centre at data rate
// - 4x modes 1,1,bypass centre at half rate
// - tuning word applies on update bit rising
// - stage modes held in registers 0x1c-0x1e
`ifndef INTERP_COARSE_MIXER_PARAMS_SVH
`define INTERP_COARSE_MIXER_PARAMS_SVH
`define REG_HB_FIRST 8'h1c
`define REG_HB_SECOND 8'h1d
`define REG_HB_THIRD 8'h1e
`define REG_CTRL 8'h1f
`define REG_TW0 8'h30
`define REG_TW1 8'h31
`define REG_TW2 8'h32
`define REG_TW3 8'h33
`define REG_TW_UPD 8'h36
`define REG_STATUS 8'h40
`define REG_ACT_TW0 8'h41
`define CTRL_PREMOD_BIT 0
`define CTRL_BYP2_BIT 1
`define CTRL_BYP3_BIT 2
`define RESET_BYTE 8'h00
// r = sqrt(2)/2 in q1.15
`define R_COEF 18'sh05a82
`define R_SHIFT 15
`define FIFO_DEPTH 8
`endif

// File: interp_coarse_mixer_pkg.sv
// types for the coarse-mixing interpolation datapath
package interp_coarse_mixer_pkg;
    typedef enum logic [2:0] {
        MIX_NONE = 3'h0,
        MIX_HALF = 3'h1,
        MIX_QUARTER = 3'h2,
        MIX_THREE_Q = 3'h3,
        MIX_EIGHTH = 3'h4
    } mix_t;
endpackage : interp_coarse_mixer_pkg

// File: interp_coarse_mixer.sv
// fifo, coarse mixer datapath and register port
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "interp_coarse_mixer_params.svh"

module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // refuse depths the wrapping pointers cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    assign in_ready_out = (cnt_r != DEPTH[AW:0]);
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out = mem_r[rp_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clock_in)
    begin
        if (push)
            mem_r[wp_r] <= in_data_in;
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule : sample_fifo

module interp_coarse_mixer #(
    parameter int SAMPLE_W = 16
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // sample input from host
    input wire logic s_valid_in,
    output logic s_ready_out,
    input wire logic [SAMPLE_W-1:0] s_i_in,
    input wire logic [SAMPLE_W-1:0] s_q_in,
    // mixed sample output
    output logic m_valid_out,
    input wire logic m_ready_in,
    output logic [SAMPLE_W-1:0] m_i_out,
    output logic [SAMPLE_W-1:0] m_q_out,
    // active nco tuning word
    output logic [31:0] tuning_word_out
);
    localparam int W = SAMPLE_W;

    // refuse widths the r product slice cannot serve
    if (W < 4 || W > 24)
    begin : g_bad_width
        $error("sample width out of range");
    end

    logic [1:0] halfband_stage_first_r;
    logic [5:0] halfband_stage_second_r;
    logic [5:0] halfband_stage_third_r;
    logic [7:0] ctrl_r;
    logic [31:0] tw_shadow_r;
    logic upd_r;
    logic [31:0] tw_active_r;
    logic [2:0] phase_r;
    logic [7:0] rdata_nxt;
    interp_coarse_mixer_pkg::mix_t mode;

    // configuration writes; stage modes live at 0x1c-0x1e
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            halfband_stage_first_r <= 2'h0;
            halfband_stage_second_r <= 6'h00;
            halfband_stage_third_r <= 6'h00;
            ctrl_r <= `RESET_BYTE;
            tw_shadow_r <= 32'h0000_0000;
            upd_r <= 1'b0;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                `REG_HB_FIRST: halfband_stage_first_r <= reg_wdata_in[1:0];
                `REG_HB_SECOND: halfband_stage_second_r <= reg_wdata_in[5:0];
                `REG_HB_THIRD: halfband_stage_third_r <= reg_wdata_in[5:0];
                `REG_CTRL: ctrl_r <= reg_wdata_in;
                `REG_TW0: tw_shadow_r[7:0] <= reg_wdata_in;
                `REG_TW1: tw_shadow_r[15:8] <= reg_wdata_in;
                `REG_TW2: tw_shadow_r[23:16] <= reg_wdata_in;
                `REG_TW3: tw_shadow_r[31:24] <= reg_wdata_in;
                `REG_TW_UPD: upd_r <= reg_wdata_in[0];
                default: ;
            endcase
        end
    end

    // tuning word copied only on 0 to 1 of the update bit
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            tw_active_r <= 32'h0000_0000;
        else if (reg_wr_in && reg_addr_in == `REG_TW_UPD
                 && reg_wdata_in[0] && !upd_r)
            tw_active_r <= tw_shadow_r;
    end
    assign tuning_word_out = tw_active_r;

    always_comb
    begin
        case (reg_addr_in)
            `REG_HB_FIRST: rdata_nxt = {6'h00, halfband_stage_first_r};
            `REG_HB_SECOND: rdata_nxt = {2'h0, halfband_stage_second_r};
            `REG_HB_THIRD: rdata_nxt = {2'h0, halfband_stage_third_r};
            `REG_CTRL: rdata_nxt = ctrl_r;
            `REG_TW0: rdata_nxt = tw_shadow_r[7:0];
            `REG_TW1: rdata_nxt = tw_shadow_r[15:8];
            `REG_TW2: rdata_nxt = tw_shadow_r[23:16];
            `REG_TW3: rdata_nxt = tw_shadow_r[31:24];
            `REG_TW_UPD: rdata_nxt = {7'h00, upd_r};
            `REG_STATUS: rdata_nxt = {2'h0, mode, phase_r};
            `REG_ACT_TW0: rdata_nxt = tw_active_r[7:0];
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
            reg_rdata_out <= rdata_nxt;
        else
            reg_rdata_out <= 8'h00;
    end

    // mode from stage settings; premod overrides them with the half-rate mode
    // offsets are whole multiples of the data rate
    always_comb
    begin
        if (ctrl_r[`CTRL_PREMOD_BIT])
            mode = interp_coarse_mixer_pkg::MIX_HALF;
        else if (!ctrl_r[`CTRL_BYP3_BIT] && halfband_stage_third_r != 6'h00)
            mode = interp_coarse_mixer_pkg::MIX_EIGHTH;
        else if (!ctrl_r[`CTRL_BYP2_BIT] && halfband_stage_second_r != 6'h00)
            mode = (halfband_stage_second_r[1:0] == 2'h3)
                ? interp_coarse_mixer_pkg::MIX_THREE_Q
                : interp_coarse_mixer_pkg::MIX_QUARTER;
        else if (halfband_stage_first_r != 2'h0)
            mode = interp_coarse_mixer_pkg::MIX_HALF;
        else
            mode = interp_coarse_mixer_pkg::MIX_NONE;
    end

    // sample buffer
    logic f_valid;
    logic f_ready;
    logic [2*W-1:0] f_data;
    sample_fifo #(
        .WIDTH(2 * W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(s_valid_in),
        .in_ready_out(s_ready_out),
        .in_data_in({s_i_in, s_q_in}),
        .out_valid_out(f_valid),
        .out_ready_in(f_ready),
        .out_data_out(f_data)
    );

    logic signed [W-1:0] si;
    logic signed [W-1:0] sq;
    logic signed [W:0] spp;
    logic signed [W:0] sqm;
    logic signed [W+17:0] rp_full;
    logic signed [W+17:0] rm_full;
    logic signed [W-1:0] rpq;
    logic signed [W-1:0] rqm;
    logic signed [W-1:0] mi_nxt;
    logic signed [W-1:0] mq_nxt;
    logic take;

    assign si = f_data[2*W-1:W];
    assign sq = f_data[W-1:0];
    assign spp = {si[W-1], si} + {sq[W-1], sq};
    assign sqm = {sq[W-1], sq} - {si[W-1], si};
    assign rp_full = spp * `R_COEF;
    assign rm_full = sqm * `R_COEF;
    assign rpq = rp_full[`R_SHIFT+W-1:`R_SHIFT];
    assign rqm = rm_full[`R_SHIFT+W-1:`R_SHIFT];
    assign f_ready = !m_valid_out || m_ready_in;
    assign take = f_valid && f_ready;

    // complex carrier multiply as sign and swap, plus r products on odd eighth-rate phases
    always_comb
    begin
        mi_nxt = si;
        mq_nxt = sq;
        case (mode)
            interp_coarse_mixer_pkg::MIX_HALF:
            begin
                mi_nxt = phase_r[0] ? -si : si;
                mq_nxt = phase_r[0] ? -sq : sq;
            end
            interp_coarse_mixer_pkg::MIX_QUARTER:
                case (phase_r[1:0])
                    2'h0: begin mi_nxt = si; mq_nxt = sq; end
                    2'h1: begin mi_nxt = sq; mq_nxt = -si; end
                    2'h2: begin mi_nxt = -si; mq_nxt = -sq; end
                    default: begin mi_nxt = -sq; mq_nxt = si; end
                endcase
            interp_coarse_mixer_pkg::MIX_THREE_Q:
                case (phase_r[1:0])
                    2'h0: begin mi_nxt = si; mq_nxt = sq; end
                    2'h1: begin mi_nxt = -sq; mq_nxt = si; end
                    2'h2: begin mi_nxt = -si; mq_nxt = -sq; end
                    default: begin mi_nxt = sq; mq_nxt = -si; end
                endcase
            interp_coarse_mixer_pkg::MIX_EIGHTH:
                case (phase_r)
                    3'h0: begin mi_nxt = si; mq_nxt = sq; end
                    3'h1: begin mi_nxt = rpq; mq_nxt = rqm; end
                    3'h2: begin mi_nxt = sq; mq_nxt = -si; end
                    3'h3: begin mi_nxt = rqm; mq_nxt = -rpq; end
                    3'h4: begin mi_nxt = -si; mq_nxt = -sq; end
                    3'h5: begin mi_nxt = -rpq; mq_nxt = -rqm; end
                    3'h6: begin mi_nxt = -sq; mq_nxt = si; end
                    default: begin mi_nxt = -rqm; mq_nxt = rpq; end
                endcase
            default: ;
        endcase
    end

    // phase steps once per sample, wraps by counter width
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            phase_r <= 3'h0;
        else if (take)
            phase_r <= phase_r + 3'h1;
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            m_valid_out <= 1'b0;
            m_i_out <= '0;
            m_q_out <= '0;
        end
        else if (f_ready)
        begin
            m_valid_out <= f_valid;
            if (f_valid)
            begin
                m_i_out <= mi_nxt;
                m_q_out <= mq_nxt;
            end
        end
    end

    // bandwidth and bus rate limits are host planning

    phase_step_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        take |=> phase_r == $past(phase_r) + 3'h1)
        else $error("phase did not advance");
    phase_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !take |=> $stable(phase_r))
        else $error("phase moved without sample");
    tw_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !(reg_wr_in && reg_addr_in == `REG_TW_UPD) |=> $stable(tw_active_r))
        else $error("tuning word changed without update");
    tw_load_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == `REG_TW_UPD && reg_wdata_in[0] && !upd_r)
        |=> tw_active_r == $past(tw_shadow_r))
        else $error("tuning word not loaded");
    half_sign_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (take && mode == interp_coarse_mixer_pkg::MIX_HALF && phase_r[0])
        |=> m_i_out == -$past(si) && m_q_out == -$past(sq))
        else $error("half-rate sign wrong");
    quarter_swap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (take && mode == interp_coarse_mixer_pkg::MIX_QUARTER
         && phase_r[1:0] == 2'h1)
        |=> m_i_out == $past(sq) && m_q_out == -$past(si))
        else $error("quarter-rate swap wrong");
    threeq_swap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (take && mode == interp_coarse_mixer_pkg::MIX_THREE_Q
         && phase_r[1:0] == 2'h1)
        |=> m_i_out == -$past(sq) && m_q_out == $past(si))
        else $error("three-quarter swap wrong");
    eighth_q_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (take && mode == interp_coarse_mixer_pkg::MIX_EIGHTH
         && phase_r == 3'h2)
        |=> m_i_out == $past(sq) && m_q_out == -$past(si))
        else $error("eighth-rate quadrature wrong");

    // unmixed sample accepted from the buffer
    sequence pass_take_s;
        take && mode == interp_coarse_mixer_pkg::MIX_NONE;
    endsequence
    pass_keep_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        pass_take_s |=> m_i_out == $past(si) && m_q_out == $past(sq))
        else $error("unmixed sample altered");
endmodule : interp_coarse_mixer

// File: host_stream_model.sv
// host model streaming i/q samples into the mixer
`timescale 1ns/1ps
module host_stream_model (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // control from bench
    input wire logic start_in,
    input wire logic [7:0] count_in,
    input wire logic pat_in,
    input wire logic [1:0] gap_in,
    // sample stream
    output logic s_valid_out,
    input wire logic s_ready_in,
    output logic [15:0] s_i_out,
    output logic [15:0] s_q_out
);
    logic [7:0] idx_r;
    logic [1:0] wait_r;
    logic busy_r;
    logic [15:0] cur_i;
    logic [15:0] cur_q;
    logic [15:0] last_i_r;
    logic [15:0] last_q_r;
    // pattern 1 keeps the r products exact
    assign cur_i = pat_in ? (idx_r[1] ? 16'he000 : 16'h2000)
                          : 16'h0100 + {8'h00, idx_r};
    assign cur_q = pat_in ? 16'h2000 : 16'h0300 + {8'h00, idx_r};
    assign s_valid_out = busy_r && wait_r == 2'h0;
    // released lines show the inverse of the last value
    assign s_i_out = s_valid_out ? cur_i : ~last_i_r;
    assign s_q_out = s_valid_out ? cur_q : ~last_q_r;
    // at most one sample per clock, far under the line ceiling
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in || start_in)
        begin
            idx_r <= 8'h00;
            wait_r <= 2'h0;
            busy_r <= start_in && !sys_rst_in;
            last_i_r <= 16'h0000;
            last_q_r <= 16'h0000;
        end
        else if (s_valid_out && s_ready_in)
        begin
            idx_r <= idx_r + 8'h01;
            wait_r <= gap_in;
            busy_r <= (idx_r + 8'h01) != count_in;
            last_i_r <= cur_i;
            last_q_r <= cur_q;
        end
        else if (wait_r != 2'h0)
        begin
            wait_r <= wait_r - 2'h1;
        end
    end
endmodule : host_stream_model

// File: test_interp_coarse_mixer.sv
// self-checking bench for the coarse mixer datapath
`timescale 1ns/1ps
`include "interp_coarse_mixer_params.svh"
module test_interp_coarse_mixer;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic s_valid_in, s_ready_out, m_valid_out;
    logic m_ready_in = 1'b1;
    logic [15:0] s_i_in, s_q_in, m_i_out, m_q_out;
    logic [31:0] tuning_word_out;
    logic start = 1'b0;
    logic pat = 1'b0;
    logic hold = 1'b0;
    logic stall = 1'b0;
    logic [1:0] gap = 2'h0;
    logic [2:0] cur_mode = 3'h0;
    logic [7:0] d;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int out_idx = 0;

    interp_coarse_mixer dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .s_valid_in(s_valid_in),
        .s_ready_out(s_ready_out), .s_i_in(s_i_in), .s_q_in(s_q_in),
        .m_valid_out(m_valid_out), .m_ready_in(m_ready_in),
        .m_i_out(m_i_out), .m_q_out(m_q_out),
        .tuning_word_out(tuning_word_out));
    host_stream_model host (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .start_in(start), .count_in(8'd12), .pat_in(pat), .gap_in(gap),
        .s_valid_out(s_valid_in), .s_ready_in(s_ready_out),
        .s_i_out(s_i_in), .s_q_out(s_q_in));

    always #5 clock_in = ~clock_in;

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check8

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
        @(posedge clock_in);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        @(posedge clock_in);
        v = reg_rdata_out;
    endtask : reg_read

    function automatic logic [15:0] samp_i(input int k);
        return pat ? (k[1] ? 16'he000 : 16'h2000) : 16'h0100 + k[15:0];
    endfunction : samp_i

    function automatic logic [15:0] samp_q(input int k);
        return pat ? 16'h2000 : 16'h0300 + k[15:0];
    endfunction : samp_q

    function automatic logic [15:0] rmul(input logic signed [16:0] x);
        logic signed [35:0] p;
        p = x * `R_COEF;
        return p[30:15];
    endfunction : rmul

    function automatic logic [31:0] mix_exp(input logic [2:0] m, input int k);
        logic [15:0] i, q, a, b;
        i = samp_i(k);
        q = samp_q(k);
        a = rmul({i[15], i} + {q[15], q});
        b = rmul({q[15], q} - {i[15], i});
        case (m)
            3'h1: return k[0] ? {-i, -q} : {i, q};
            3'h2: return k[1] ? (k[0] ? {-q, i} : {-i, -q})
                              : (k[0] ? {q, -i} : {i, q});
            3'h3: return k[1] ? (k[0] ? {q, -i} : {-i, -q})
                              : (k[0] ? {-q, i} : {i, q});
            3'h4:
            begin
                case (k[2:0])
                    3'h1: return {a, b};
                    3'h2: return {q, -i};
                    3'h3: return {b, -a};
                    3'h4: return {-i, -q};
                    3'h5: return {-a, -b};
                    3'h6: return {-q, i};
                    3'h7: return {-b, a};
                    default: return {i, q};
                endcase
            end
            default: return {i, q};
        endcase
    endfunction : mix_exp

    always @(posedge clock_in)
    begin
        cycles++;
        if (!sys_rst_in && m_valid_out && m_ready_in)
        begin
            check32({m_i_out, m_q_out}, mix_exp(cur_mode, out_idx));
            out_idx++;
        end
        m_ready_in <= !hold && !(stall && cycles[1]);
        if (cycles > 20000)
        begin
            err_count++;
            close_out();
        end
    end

    task automatic do_reset;
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
    endtask : do_reset

    task automatic run_mode(input logic [2:0] m, input logic [7:0] f,
        input logic [7:0] s, input logic [7:0] t, input logic [7:0] c,
        input logic p, input logic [1:0] g, input logic st, input logic h);
        do_reset();
        cur_mode <= m;
        pat <= p;
        gap <= g;
        stall <= st;
        hold <= h;
        out_idx = 0;
        reg_write(8'h1c, f);
        reg_write(8'h1d, s);
        reg_write(8'h1e, t);
        reg_write(8'h1f, c);
        reg_read(8'h40, d);
        check8(d, {2'b00, m, 3'h0});
        start <= 1'b1;
        @(posedge clock_in);
        start <= 1'b0;
        if (h)
        begin
            repeat (30) @(posedge clock_in);
            check8({7'h00, s_ready_out}, 8'h00);
            hold <= 1'b0;
        end
        for (int n = 0; n < 400 && out_idx < 12; n++)
            @(posedge clock_in);
        check8(out_idx[7:0], 8'd12);
        $display("mode %0d test done", m);
    endtask : run_mode

    initial
    begin
        do_reset();
        reg_read(8'h1c, d);
        check8(d, 8'h00);
        reg_read(8'h1e, d);
        check8(d, 8'h00);
        reg_write(8'h1c, 8'hff);
        reg_read(8'h1c, d);
        check8(d, 8'h03);
        reg_write(8'h1d, 8'hff);
        reg_read(8'h1d, d);
        check8(d, 8'h3f);
        reg_write(8'h50, 8'hff);
        reg_read(8'h50, d);
        check8(d, 8'h00);
        // word for a carrier of one tenth of the nco clock
        reg_write(8'h30, 8'h99);
        reg_write(8'h31, 8'h99);
        reg_write(8'h32, 8'h99);
        reg_write(8'h33, 8'h19);
        check32(tuning_word_out, 32'h00000000);
        reg_write(8'h36, 8'h01);
        check32(tuning_word_out, 32'h19999999);
        reg_read(8'h41, d);
        check8(d, 8'h99);
        reg_write(8'h30, 8'h00);
        reg_write(8'h36, 8'h01);
        check32(tuning_word_out, 32'h19999999);
        reg_write(8'h36, 8'h00);
        reg_write(8'h36, 8'h01);
        check32(tuning_word_out, 32'h19999900);
        $display("register test done");
        run_mode(3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0, 1'b0, 1'b1);
        run_mode(3'h1, 8'h02, 8'h00, 8'h00, 8'h00, 1'b0, 2'h1, 1'b0, 1'b0);
        run_mode(3'h1, 8'h01, 8'h00, 8'h00, 8'h01, 1'b0, 2'h0, 1'b1, 1'b0);
        run_mode(3'h2, 8'h00, 8'h09, 8'h00, 8'h00, 1'b0, 2'h0, 1'b1, 1'b0);
        run_mode(3'h3, 8'h00, 8'h1b, 8'h00, 8'h00, 1'b0, 2'h2, 1'b0, 1'b0);
        run_mode(3'h4, 8'h02, 8'h12, 8'h09, 8'h00, 1'b1, 2'h0, 1'b1, 1'b0);
        run_mode(3'h2, 8'h01, 8'h09, 8'h09, 8'h04, 1'b0, 2'h0, 1'b0, 1'b0);
        // second stage bypassed falls back to first-stage half rate
        run_mode(3'h1, 8'h01, 8'h09, 8'h00, 8'h02, 1'b0, 2'h0, 1'b0, 1'b0);
        close_out();
    end
endmodule : test_interp_coarse_mixer
